// ==== wcr_recorder.v ====
// Waveform capture recorder core with AHB-Lite register slave.
// Assumes measurement samples arrive synchronous to hclk with a valid pulse.
//
// Overview of operation
// - A record starts when the configured trigger operand rises.
// - Several records may fill at once; a new trigger is not locked out.
// - A fixed store is split evenly over the configured record count.
// - With automatic overwrite, a trigger reuses the oldest slot when full, once that slot is done filling.
// - Trigger position is the percent of the record kept before the trigger.
// - The trigger operand is always stored as a digital trace.
// - Input sampling is fixed at 64 samples per cycle.
// - Stored analog rate is decimated to 8, 16, 32 or 64 per cycle.
// - Analog trace channels set off are excluded from the record.
// - All eight channels of each installed measurement module are stored.
// - With no analog sources, records hold digital traces only.
// - Changing the record count erases all stored records.
// - Cycles per record is readable as a status value.
`timescale 1ns/100ps
`include "wcr_consts.vh"
module wcr_recorder
#(
    parameter NSLOT = 16,
    parameter NOPER = 32,
    parameter NANA = 16,
    parameter STORE_WORDS = 65536,
    parameter AW = 16
)
(
    hclk,
    hresetn,
    ce,
    hsel,
    haddr,
    htrans,
    hwrite,
    hsize,
    hwdata,
    hready,
    hrdata,
    hreadyout,
    hresp,
    sample_vld,
    operands,
    meas_modules,
    ana_modules,
    wr_en,
    wr_addr,
    wr_digital,
    wr_analog_keep,
    rec_done
);
    input wire hclk;
    input wire hresetn;
    input wire ce;
    input wire hsel;
    input wire [31:0] haddr;
    input wire [1:0] htrans;
    input wire hwrite;
    input wire [2:0] hsize;
    input wire [31:0] hwdata;
    input wire hready;
    output reg [31:0] hrdata;
    output reg hreadyout;
    output reg hresp;
    input wire sample_vld;
    input wire [NOPER-1:0] operands;
    input wire [1:0] meas_modules;
    input wire [1:0] ana_modules;
    output reg wr_en;
    output reg [AW-1:0] wr_addr;
    output reg wr_digital;
    output reg wr_analog_keep;
    output reg [NSLOT-1:0] rec_done;

    // ==================================================================
    // Registers
    reg [31:0] ctrl_ff;
    reg [31:0] trig_ff;
    reg [31:0] ana_ff;
    reg [31:0] dig_ff;
    reg [AW-1:0] raddr_ff;
    reg ap_wr_ff;
    reg [11:0] ap_ofs_ff;
    reg trig_prev_ff;
    reg [AW-1:0] wptr_ff;
    reg [3:0] oldest_ff;
    reg [3:0] next_ff;

    wire [3:0] nrec_cfg = ctrl_ff[`WCR_CTRL_NREC_MSB:`WCR_CTRL_NREC_LSB];
    wire [1:0] rate = ctrl_ff[`WCR_CTRL_RATE_MSB:`WCR_CTRL_RATE_LSB];
    wire ovw = ctrl_ff[`WCR_CTRL_OVW_BIT];
    wire [6:0] pos = ctrl_ff[`WCR_CTRL_POS_MSB:`WCR_CTRL_POS_LSB];
    wire [4:0] nrec = {1'b0, nrec_cfg} + 5'h1;

    // Count of set bits, used for analog and digital widths
    function [5:0] popcnt;
        input [31:0] v;
        integer i;
        begin
            popcnt = 6'h0;
            for (i = 0; i < 32; i = i + 1)
                popcnt = popcnt + {5'h0, v[i]};
        end
    endfunction

    // ==================================================================
    // Record sizing
    reg [7:0] n_ana;
    reg [7:0] n_dig;
    reg [7:0] words;
    reg [6:0] pos_c;
    reg [31:0] slot_w;
    reg [31:0] samp_w;
    reg [31:0] per_cyc_w;
    reg [31:0] cyc_w;
    reg [31:0] post_w;
    reg [AW:0] slot_len;
    reg [AW-1:0] cyc_per_rec;
    reg [AW:0] post_len;
    always @*
    begin
        n_ana = {3'h0, meas_modules, 3'h0};
        n_ana = n_ana + {2'h0, popcnt({{(32-NANA){1'b0}},
                ana_ff[NANA-1:0] & {NANA{ana_modules != 2'h0}}})};
        if (meas_modules == 2'h0 && ana_modules == 2'h0)
            n_ana = 8'h0;
        n_dig = {2'h0, popcnt(dig_ff)} + 8'h1;
        words = n_ana + ((n_dig + 8'hF) >> 4);
        slot_w = STORE_WORDS / {27'h0, nrec};
        slot_len = slot_w[AW:0];
        per_cyc_w = {24'h0, words} << ({3'h0, rate} + 5'h3);
        cyc_w = slot_w / per_cyc_w;
        cyc_per_rec = cyc_w[AW-1:0];
        // post share of record, position capped at full
        pos_c = (pos > `WCR_PCT_FULL) ? `WCR_PCT_FULL : pos;
        samp_w = slot_w / {24'h0, words};
        post_w = samp_w - (samp_w * {25'h0, pos_c}) /
            {25'h0, `WCR_PCT_FULL};
        post_len = post_w[AW:0];
    end

    // ==================================================================
    // Trigger and slot allocation
    wire [NSLOT-1:0] sfill;
    wire [NSLOT-1:0] sdone;
    wire [NSLOT-1:0] sfull;
    wire [NSLOT-1:0] all_slots;
    wire keep;
    reg clr_all;
    wire trig_now = operands[trig_ff[4:0]];
    wire trig_rise = trig_now & ~trig_prev_ff;
    wire next_free = ~sfull[next_ff];
    wire take = trig_rise & (next_free | (ovw & ~sfill[oldest_ff]));
    wire [3:0] tslot = next_free ? next_ff : oldest_ff;

    genvar g;
    generate
        for (g = 0; g < NSLOT; g = g + 1)
        begin : g_slot
            assign all_slots[g] = (g < nrec);
            wcr_slot #(.CW(AW + 1)) u_slot
            (
                .hclk(hclk),
                .hresetn(hresetn),
                .ce(ce),
                .clr(clr_all),
                .start(take && tslot == g),
                .post_len(post_len),
                .adv(keep),
                .filling(sfill[g]),
                .done_o(sdone[g]),
                .full_o(sfull[g])
            );
        end
    endgenerate

    wcr_decim u_decim
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .rate(rate),
        .sample_vld(sample_vld),
        .keep(keep)
    );

    // ==================================================================
    // AHB-Lite slave
    wire ap = hsel & htrans[1] & hready & (hsize == 3'h2);
    wire [11:0] rd_ofs = {haddr[11:2], 2'h0};
    reg [31:0] rd_mux;
    always @*
    begin
        case (rd_ofs)
            `WCR_OFS_CTRL: rd_mux = ctrl_ff;
            `WCR_OFS_TRIG: rd_mux = trig_ff;
            `WCR_OFS_ANA: rd_mux = ana_ff;
            `WCR_OFS_DIG: rd_mux = dig_ff;
            `WCR_OFS_STAT: rd_mux = {sdone & all_slots, sfill & all_slots};
            `WCR_OFS_LEN: rd_mux = {{(32-AW){1'b0}}, cyc_per_rec};
            `WCR_OFS_RADDR: rd_mux = {{(32-AW){1'b0}}, raddr_ff};
            `WCR_OFS_RDATA: rd_mux = {{(31-AW){1'b0}}, slot_len};
            `WCR_OFS_DONE: rd_mux = {{(32-NSLOT){1'b0}}, sdone};
            `WCR_OFS_MODS: rd_mux = {28'h0, ana_modules, meas_modules};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always @*
    begin
        clr_all = ap_wr_ff && ap_ofs_ff == `WCR_OFS_CTRL &&
            hwdata[`WCR_CTRL_NREC_MSB:`WCR_CTRL_NREC_LSB] != nrec_cfg;
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_ff <= `WCR_CTRL_RESET;
            trig_ff <= 32'h0000_0000;
            ana_ff <= 32'h0000_0000;
            dig_ff <= 32'h0000_0000;
            raddr_ff <= {AW{1'b0}};
            ap_wr_ff <= 1'b0;
            ap_ofs_ff <= 12'h000;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else if (ce)
        begin
            ap_wr_ff <= ap & hwrite;
            if (ap)
                ap_ofs_ff <= rd_ofs;
            hrdata <= 32'h0000_0000;
            if (ap_wr_ff)
            begin
                case (ap_ofs_ff)
                    `WCR_OFS_CTRL: ctrl_ff <= hwdata & 32'h0000_7F7F;
                    `WCR_OFS_TRIG: trig_ff <= {27'h0, hwdata[4:0]};
                    `WCR_OFS_ANA: ana_ff <= hwdata;
                    `WCR_OFS_DIG: dig_ff <= hwdata;
                    `WCR_OFS_RADDR: raddr_ff <= hwdata[AW-1:0];
                    default: ;
                endcase
            end
            // Read data stands in the data phase; a read right behind
            // a write to the same register sees the old value
            if (ap & ~hwrite)
                hrdata <= rd_mux;
        end
    end

    // ==================================================================
    // Write path and slot order
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            trig_prev_ff <= 1'b0;
            wptr_ff <= {AW{1'b0}};
            oldest_ff <= 4'h0;
            next_ff <= 4'h0;
            wr_en <= 1'b0;
            wr_addr <= {AW{1'b0}};
            wr_digital <= 1'b0;
            wr_analog_keep <= 1'b0;
            rec_done <= {NSLOT{1'b0}};
        end
        else if (ce)
        begin
            trig_prev_ff <= trig_now;
            rec_done <= sdone;
            wr_en <= sample_vld;
            wr_digital <= sample_vld;
            wr_analog_keep <= keep & (n_ana != 8'h0);
            wr_addr <= wptr_ff;
            if (sample_vld)
                wptr_ff <= (wptr_ff + {{(AW-1){1'b0}}, 1'b1} >= slot_len)
                    ? {AW{1'b0}} : wptr_ff + {{(AW-1){1'b0}}, 1'b1};
            if (clr_all)
            begin
                oldest_ff <= 4'h0;
                next_ff <= 4'h0;
            end
            else if (take)
            begin
                next_ff <= ({1'b0, tslot} + 5'h1 >= nrec) ? 4'h0
                    : tslot + 4'h1;
                if (!next_free)
                    oldest_ff <= ({1'b0, oldest_ff} + 5'h1 >= nrec) ? 4'h0
                        : oldest_ff + 4'h1;
            end
        end
    end
endmodule // wcr_recorder

// ==== wcr_consts.vh ====
// Constants for the waveform capture recorder: register map, fields, resets.
// Included by every design file of the recorder; definitions only.
`ifndef WCR_CONSTS_VH
`define WCR_CONSTS_VH

// ==================================================================
// Register byte offsets
`define WCR_OFS_CTRL 12'h000
`define WCR_OFS_TRIG 12'h004
`define WCR_OFS_ANA 12'h008
`define WCR_OFS_DIG 12'h00C
`define WCR_OFS_STAT 12'h010
`define WCR_OFS_LEN 12'h014
`define WCR_OFS_RADDR 12'h018
`define WCR_OFS_RDATA 12'h01C
`define WCR_OFS_DONE 12'h020
`define WCR_OFS_MODS 12'h024

// ==================================================================
// Control register fields
`define WCR_CTRL_NREC_LSB 0
`define WCR_CTRL_NREC_MSB 3
`define WCR_CTRL_RATE_LSB 4
`define WCR_CTRL_RATE_MSB 5
`define WCR_CTRL_OVW_BIT 6
`define WCR_CTRL_POS_LSB 8
`define WCR_CTRL_POS_MSB 14
`define WCR_CTRL_RESET 32'h0000_1901

// Stored rate codes: 0=8, 1=16, 2=32, 3=64 samples per cycle
`define WCR_RATE_8 2'h0
`define WCR_RATE_64 2'h3

// Internal sampling rate and trigger position full scale (percent)
`define WCR_SAMPLES_PER_CYCLE 64
`define WCR_PCT_FULL 7'h64

`endif

// ==== wcr_decim.v ====
// Decimator: passes one of every N input samples for storage.
// Assumes sample_vld pulses once per 64-per-cycle input sample.
`timescale 1ns/100ps
`include "wcr_consts.vh"
module wcr_decim
(
    hclk,
    hresetn,
    ce,
    rate,
    sample_vld,
    keep
);
    input wire hclk;
    input wire hresetn;
    input wire ce;
    input wire [1:0] rate;
    input wire sample_vld;
    output reg keep;

    reg [2:0] phase_ff;
    reg [2:0] mask;

    // Phase mask: 8/cycle keeps 1 of 8, 64/cycle keeps all
    always @*
    begin
        case (rate)
            2'h0: mask = 3'h7;
            2'h1: mask = 3'h3;
            2'h2: mask = 3'h1;
            default: mask = 3'h0;
        endcase
    end

    always @*
    begin
        keep = sample_vld & ((phase_ff & mask) == 3'h0);
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            phase_ff <= 3'h0;
        else if (ce && sample_vld)
            phase_ff <= phase_ff + 3'h1;
    end
endmodule // wcr_decim

// ==== wcr_slot.v ====
// Per-record slot tracker: fill state and post-trigger countdown.
// Assumes start/adv/clr pulses from the recorder core, one clock each.
`timescale 1ns/100ps
`include "wcr_consts.vh"
module wcr_slot
#(
    parameter CW = 16
)
(
    hclk,
    hresetn,
    ce,
    clr,
    start,
    post_len,
    adv,
    filling,
    done_o,
    full_o
);
    input wire hclk;
    input wire hresetn;
    input wire ce;
    input wire clr;
    input wire start;
    input wire [CW-1:0] post_len;
    input wire adv;
    output reg filling;
    output reg done_o;
    output wire full_o;

    reg [CW-1:0] left_ff;

    assign full_o = filling | done_o;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            filling <= 1'b0;
            done_o <= 1'b0;
            left_ff <= {CW{1'b0}};
        end
        else if (ce)
        begin
            if (clr)
            begin
                filling <= 1'b0;
                done_o <= 1'b0;
            end
            else if (start)
            begin
                filling <= 1'b1;
                done_o <= 1'b0;
                left_ff <= post_len;
            end
            else if (filling && adv)
            begin
                if (left_ff <= {{(CW-1){1'b0}}, 1'b1})
                begin
                    filling <= 1'b0;
                    done_o <= 1'b1;
                end
                left_ff <= left_ff - {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // wcr_slot

// ==== wcr_rec_asserts.sv ====
// Checker for the waveform capture recorder top-level ports.
// Bound to wcr_recorder; one clock, async active-low reset.
`timescale 1ns/100ps
module wcr_rec_asserts
#(
    parameter NSLOT = 16,
    parameter STORE_WORDS = 65536,
    parameter AW = 16
)
(
    input wire hclk,
    input wire hresetn,
    input wire ce,
    input wire sample_vld,
    input wire [1:0] meas_modules,
    input wire [1:0] ana_modules,
    input wire hreadyout,
    input wire hresp,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire wr_digital,
    input wire wr_analog_keep,
    input wire [NSLOT-1:0] rec_done
);
    default clocking dc @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // ==========================================================
    // Properties
    property p_ready;
        hreadyout && !hresp;
    endproperty
    property p_wr_src;
        $rose(wr_en) |-> $past(sample_vld) || $past(sample_vld, 2)
            || $past(sample_vld, 3);
    endproperty
    property p_keep;
        wr_analog_keep |-> wr_en;
    endproperty
    property p_dig;
        wr_en |-> wr_digital;
    endproperty
    property p_noana;
        (meas_modules == 2'h0 && ana_modules == 2'h0) [*3]
            |-> !wr_analog_keep;
    endproperty
    property p_addr;
        wr_en |-> wr_addr < STORE_WORDS;
    endproperty
    property p_done;
        (rec_done & ~$past(rec_done)) != 0 |-> wr_en || $past(wr_en)
            || $past(wr_en, 2) || $past(wr_en, 3);
    endproperty
    property p_ce;
        !ce |=> $stable(wr_addr);
    endproperty

    // ==========================================================
    // Assertions and covers
    a_ready: assert property (p_ready)
        else $error("bus slave not ready or not okay");
    a_wr_src: assert property (p_wr_src)
        else $error("store write without input sample");
    a_keep: assert property (p_keep)
        else $error("analog kept without store write");
    a_dig: assert property (p_dig)
        else $error("store write without digital traces");
    a_noana: assert property (p_noana)
        else $error("analog written with no analog source");
    a_addr: assert property (p_addr)
        else $error("write pointer beyond store");
    a_done: assert property (p_done)
        else $error("record done without a store write");
    a_ce: assert property (p_ce)
        else $error("pointer moved while clock enable low");
    c_two: cover property ($countones(rec_done) == 2);
    c_keep: cover property (wr_analog_keep);
    c_hold: cover property (!ce ##1 !ce);
endmodule // wcr_rec_asserts

bind wcr_recorder wcr_rec_asserts #(.NSLOT(NSLOT),
    .STORE_WORDS(STORE_WORDS), .AW(AW)) u_wcr_rec_asserts (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .sample_vld(sample_vld),
    .meas_modules(meas_modules), .ana_modules(ana_modules),
    .hreadyout(hreadyout), .hresp(hresp), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_digital(wr_digital),
    .wr_analog_keep(wr_analog_keep), .rec_done(rec_done));

// ==== wcr_meas_model.sv ====
// Measurement module model: one sample strobe every PER clocks.
// Assumes the recorder clock; run starts and stops the stream.
`timescale 1ns/100ps
module wcr_meas_model
#(
    parameter PER = 4
)
(
    input wire hclk,
    input wire hresetn,
    input wire run,
    output logic sample_vld
);
    int cnt_ff;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_ff <= 0;
            sample_vld <= 1'b0;
        end
        else
        begin
            cnt_ff <= (cnt_ff == PER - 1 || !run) ? 0 : cnt_ff + 1;
            sample_vld <= run && cnt_ff == PER - 1;
        end
    end
endmodule // wcr_meas_model

// ==== wcr_recorder_tb_top.sv ====
// Testbench for the waveform capture recorder.
// Drives AHB-Lite and operands; the measurement model feeds samples.
`timescale 1ns/100ps
`include "wcr_consts.vh"
module wcr_recorder_tb_top;
    logic hclk, hresetn, ce, hsel, hwrite, run, ok;
    logic hreadyout, hresp, sample_vld, wr_en, wr_digital, wr_analog_keep;
    logic [1:0] htrans, meas_modules, ana_modules;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, operands, hrdata, rd, l_a;
    logic [15:0] wr_addr, rec_done;
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;

    localparam int STORE = 4096;

    wcr_recorder #(.STORE_WORDS(STORE)) u_wcr_recorder (.hclk(hclk),
        .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sample_vld(sample_vld), .operands(operands),
        .meas_modules(meas_modules), .ana_modules(ana_modules),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_digital(wr_digital),
        .wr_analog_keep(wr_analog_keep), .rec_done(rec_done));
    wcr_meas_model u_wcr_meas_model (.hclk(hclk), .hresetn(hresetn),
        .run(run), .sample_vld(sample_vld));

    // ==========================================================
    // Clock, timeout, reporting
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // ==========================================================
    // Bus and stimulus helpers
    task automatic ahb(input logic w, input logic [31:0] a, d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        do
        begin
            @(negedge hclk);
            ok = hreadyout;
            @(posedge hclk);
        end
        while (ok !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do
        begin
            @(negedge hclk);
            ok = hreadyout;
            rd = hrdata;
            @(posedge hclk);
        end
        while (ok !== 1'b1);
    endtask

    task automatic len_rd();
        repeat (40) @(posedge hclk);
        ahb(1'b0, `WCR_OFS_LEN, 32'h0);
    endtask

    task automatic trig(input int b);
        operands[b] <= 1'b1;
        repeat (8) @(posedge hclk);
        operands[b] <= 1'b0;
        repeat (8) @(posedge hclk);
    endtask

    task automatic wait_n(input int n);
        int k;
        k = 0;
        do
        begin
            @(negedge hclk);
            k++;
        end
        while ($countones(rec_done) != n && k < 8000);
        @(posedge hclk);
    endtask

    task automatic chk_done(input int n);
        @(negedge hclk);
        chk($countones(rec_done), n);
        @(posedge hclk);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        ahb(1'b0, `WCR_OFS_CTRL, 32'h0);
        chk(rd, `WCR_CTRL_RESET);
        ahb(1'b1, 32'h0000_0040, 32'hFFFF_FFFF);
        ahb(1'b0, 32'h0000_0040, 32'h0);
        chk(rd, 32'h0);
        $display("t_regs finished");
    endtask

    task automatic t_length();
        ahb(1'b1, `WCR_OFS_ANA, 32'h0000_FFFF);
        len_rd();
        l_a = rd;
        chk(l_a != 32'h0, 32'h1);
        ahb(1'b1, `WCR_OFS_CTRL, 32'h0000_1903);
        len_rd();
        chk(rd < l_a, 32'h1);
        l_a = rd;
        ahb(1'b0, `WCR_OFS_RDATA, 32'h0);
        chk(rd, STORE / 4);
        ahb(1'b1, `WCR_OFS_ANA, 32'h0);
        len_rd();
        chk(rd > l_a, 32'h1);
        l_a = rd;
        ahb(1'b1, `WCR_OFS_CTRL, 32'h0000_1933);
        len_rd();
        chk(rd < l_a, 32'h1);
        ahb(1'b1, `WCR_OFS_CTRL, 32'h0000_1903);
        $display("t_length finished");
    endtask

    task automatic t_capture();
        ahb(1'b1, `WCR_OFS_TRIG, 32'h0000_0005);
        run <= 1'b1;
        operands[6] <= 1'b1;
        repeat (20) @(posedge hclk);
        ahb(1'b0, `WCR_OFS_STAT, 32'h0);
        chk(rd[15:0], 32'h0);
        trig(5);
        ahb(1'b0, `WCR_OFS_STAT, 32'h0);
        chk($countones(rd[15:0]), 32'h1);
        ce <= 1'b0;
        repeat (3) @(posedge hclk);
        ce <= 1'b1;
        trig(5);
        wait_n(2);
        chk_done(2);
        ahb(1'b0, `WCR_OFS_STAT, 32'h0);
        chk($countones(rd[31:16]), 32'h2);
        $display("t_capture finished");
    endtask

    task automatic t_clear();
        ahb(1'b1, `WCR_OFS_CTRL, 32'h0000_4B71);
        repeat (3) @(posedge hclk);
        chk_done(0);
        $display("t_clear finished");
    endtask

    task automatic t_overwrite();
        meas_modules <= 2'h0;
        ana_modules <= 2'h0;
        trig(5);
        wait_n(1);
        trig(5);
        wait_n(2);
        trig(5);
        chk_done(1);
        wait_n(2);
        chk_done(2);
        $display("t_overwrite finished");
    endtask

    initial
    begin
        hresetn = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        operands = 32'h0;
        meas_modules = 2'h1;
        ana_modules = 2'h1;
        run = 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_length();
        t_capture();
        t_clear();
        t_overwrite();
        complete_run();
    end
endmodule // wcr_recorder_tb_top
